// File: bus_assertions.sv
// checker on the bus control ports
`timescale 1ns/1ps
module bus_assertions (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic rd_n_q,
  input wire logic wr_n_q,
  input wire logic ale_q,
  input wire logic read_data_enable_n_q,
  input wire logic ad_oe_n_q,
  input wire logic ctl_oe_n_q,
  input wire logic bus_grant_out_q,
  input wire logic bus_grant_oe_n_q,
  input wire logic system_clock_out_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  AST_RD_FREE: assert property (!read_data_enable_n_q |-> ad_oe_n_q) else $error("bus driven in read");
  AST_IDLE: assert property ((rd_n_q && wr_n_q)[*3] |-> ad_oe_n_q && !ale_q) else $error("idle bus driven");
  AST_GRANT: assert property (!bus_grant_out_q && $past(!bus_grant_out_q) |-> ctl_oe_n_q && ad_oe_n_q)
    else $error("drive in grant");
  AST_FLT: assert property (bus_grant_oe_n_q |-> ctl_oe_n_q && ad_oe_n_q) else $error("drive in float");
  AST_ALE: assert property ($rose(ale_q) |-> (rd_n_q ^ wr_n_q) ##1 !ale_q) else $error("bad latch strobe");
  AST_ONE: assert property (rd_n_q || wr_n_q) else $error("both strobes");
  AST_CLK: assert property ($past(reset_n) |-> system_clock_out_q != $past(system_clock_out_q))
    else $error("clock stuck");
  cover property ($rose(ale_q) && !rd_n_q);
  cover property ($rose(ale_q) && !wr_n_q);
  cover property ($fell(bus_grant_out_q));
endmodule
bind bus_transceiver_control bus_assertions chk (.mclk(mclk), .reset_n(reset_n), .rd_n_q(rd_n_q), .wr_n_q(wr_n_q),
  .ale_q(ale_q), .read_data_enable_n_q(read_data_enable_n_q), .ad_oe_n_q(ad_oe_n_q), .ctl_oe_n_q(ctl_oe_n_q),
  .bus_grant_out_q(bus_grant_out_q), .bus_grant_oe_n_q(bus_grant_oe_n_q), .system_clock_out_q(system_clock_out_q));

// File: bus_pkg.sv
// shared constants and types for the processor bus interface
package bus_pkg;
  localparam int AD_W        = 32;
  localparam int DIAG_W      = 2;
  localparam int BE_W        = 4;
  localparam int MODE_W      = 2;
  localparam logic [1:0] CYC_IDLE  = 2'h0;
  localparam logic [1:0] CYC_READ  = 2'h1;
  localparam logic [1:0] CYC_WRITE = 2'h2;
  localparam logic FLOAT_ALL_MODE  = 1'h1;
  localparam logic [3:0] RESET_STRB = 4'hF;
  typedef enum {ST_IDLE, ST_ADDR, ST_DATA, ST_END} bus_state_t;
endpackage

// File: bus_transceiver_control.sv
// processor side bus sequencer: address/data phases and float control
// What the document asks of this block and of the outside logic
// RULE1: outside logic may latch fetch type with the address latch strobe.
// RULE2: next address may start half a clock after read data sampling.
// RULE3: read data enable opens read transceivers, gated by bank select outside.
// RULE4: outside write enable from write strobe, held until data stored.
// RULE5: with wait states, delay outside write enable past address phase.
// RULE6: on read-to-write, delay write enable until read memory releases.
// RULE7: partial writes select only written devices or byte lanes.
// RULE8: change single-pin transceiver direction only while outputs disabled.
// RULE9: outside enable window from read and write strobes, dropped with read.
// RULE10: write data stays valid half a clock after write strobe negates.
// RULE11: direction set before enable, held one edge after strobe deasserts.
// RULE12: no cycle in progress: bus floats, control outputs negated.
// RULE13: bus floats after a cycle when no further cycle is pending.
// RULE14: after granting the bus to a DMA master, float all bus outputs. Here diag_q has no output enable and stays driven.
// RULE15: float-all reset mode floats every output except system clock. Here diag_q has no output enable and stays driven.
// RULE16: float-all mode chosen by second interrupt input during reset.
// RULE17: control outputs assert and deassert on the sequencer's clock edges.
// RULE18: outside transceiver logic clocked from system clock, held off in reset.
`timescale 1ns/1ps
module bus_transceiver_control (
  input  wire logic                    mclk,
  input  wire logic                    reset_n,
  input  wire logic                    req_valid,
  input  wire logic                    req_write,
  input  wire logic [bus_pkg::AD_W-1:0]   req_addr,
  input  wire logic [bus_pkg::BE_W-1:0]   req_be_n,
  input  wire logic [bus_pkg::DIAG_W-1:0] req_diag,
  input  wire logic [bus_pkg::AD_W-1:0]   req_wdata,
  output logic                         req_ready_q,
  output logic [bus_pkg::AD_W-1:0]     rdata_q,
  output logic                         rdata_valid_q,
  input  wire logic                    ack_n,
  input  wire logic                    bus_req_n,
  input  wire logic                    second_interrupt_input,
  input  wire logic [bus_pkg::AD_W-1:0] ad_in,
  output logic [bus_pkg::AD_W-1:0]     ad_out_q,
  output logic                         ad_oe_n_q,
  output logic [bus_pkg::DIAG_W-1:0]   diag_q,
  output logic                         rd_n_q,
  output logic                         wr_n_q,
  output logic                         ale_q,
  output logic                         read_data_enable_n_q,
  output logic                         ctl_oe_n_q,
  output logic                         bus_grant_out_q,
  output logic                         bus_grant_oe_n_q,
  output logic                         system_clock_out_q
);
  import bus_pkg::*;

  ctl_if c ();
  bus_state_t st_q;
  logic       wr_cyc_q;
  logic       float_all_q;
  logic       grant_q;
  logic [1:0] ack_s_q;
  logic [1:0] breq_s_q;
  logic [1:0] sint_s_q;
  logic [AD_W-1:0] ad_s0_q;
  logic [AD_W-1:0] ad_s1_q;
  logic       take;
  logic       rd_done;

  // control pin synchronisers
  always_ff @(posedge mclk) begin
    ack_s_q  <= {ack_s_q[0], ack_n};
    breq_s_q <= {breq_s_q[0], bus_req_n};
    sint_s_q <= {sint_s_q[0], second_interrupt_input};
  end

  // read data settles no later than its ack and clears the same two stages
  always_ff @(posedge mclk) begin
    ad_s0_q <= ad_in;
    ad_s1_q <= ad_s0_q;
  end

  // mode strap caught while reset is held, kept afterwards
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      float_all_q <= (sint_s_q[1] == FLOAT_ALL_MODE); // RULE16
    end
  end

  // start only when the bus is ours and the last ack has cleared
  always_comb begin
    take    = (st_q == ST_IDLE) && req_valid && breq_s_q[1] && !float_all_q && ack_s_q[1];
    rd_done = (st_q == ST_DATA) && !ack_s_q[1] && !wr_cyc_q;
  end

  // bus cycle sequencer
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      st_q <= ST_IDLE;
    end else begin
      unique case (st_q)
        ST_IDLE: if (take) st_q <= ST_ADDR;
        ST_ADDR: st_q <= ST_DATA;
        ST_DATA: if (!ack_s_q[1]) st_q <= ST_END;
        // one cycle hold: write data stays after strobe negation
        ST_END:  st_q <= ST_IDLE; // RULE10 RULE2
      endcase
    end
  end

  // direction of the cycle, fixed when it starts
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wr_cyc_q <= 1'h0;
    end else if (take) begin
      wr_cyc_q <= req_write;
    end
  end

  // bus handed to an outside master only between cycles
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      grant_q <= 1'h0;
    end else if (st_q == ST_IDLE) begin
      grant_q <= !breq_s_q[1] || float_all_q; // RULE14
    end
  end

  // control levels toward edge stage
  always_comb begin
    c.ale                = (st_q == ST_ADDR);
    c.rd_n               = !((st_q == ST_ADDR || st_q == ST_DATA) && !wr_cyc_q); // RULE17
    c.wr_n               = !((st_q == ST_ADDR || st_q == ST_DATA) && wr_cyc_q);
    c.read_data_enable_n = !(st_q == ST_DATA && !wr_cyc_q); // RULE3
    c.ad_drive           = (st_q == ST_ADDR) || (wr_cyc_q && (st_q == ST_DATA || st_q == ST_END));
    c.ctl_float          = grant_q || float_all_q; // RULE15
  end

  ctl_edge u_edge (
    .mclk                 (mclk),
    .reset_n              (reset_n),
    .c                    (c),
    .rd_n_q               (rd_n_q),
    .wr_n_q               (wr_n_q),
    .ale_q                (ale_q),
    .read_data_enable_n_q (read_data_enable_n_q),
    .ctl_oe_n_q           (ctl_oe_n_q)
  );

  // address/data pins, float when idle or granted
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ad_oe_n_q <= 1'h1;
    end else begin
      ad_oe_n_q <= !(c.ad_drive && !c.ctl_float); // RULE12 RULE13 RULE14
    end
  end

  // address and byte enables stand while the latch strobe is high, then write data
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ad_out_q <= '0;
    end else if (take) begin
      ad_out_q <= {req_addr[AD_W-1:BE_W], req_be_n};
    end else if (st_q == ST_DATA && wr_cyc_q) begin
      ad_out_q <= req_wdata;
    end
  end

  // fetch type rides with the address
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      diag_q <= '0;
    end else if (take) begin
      diag_q <= req_diag; // RULE1
    end
  end

  // grant pin, low while an outside master owns the bus
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      bus_grant_out_q <= 1'h1;
    end else begin
      bus_grant_out_q <= !grant_q;
    end
  end

  // grant pin floats too in float-all mode
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      bus_grant_oe_n_q <= 1'h1;
    end else begin
      bus_grant_oe_n_q <= float_all_q; // RULE16
    end
  end

  // clock out keeps running in every mode
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      system_clock_out_q <= 1'h0;
    end else begin
      system_clock_out_q <= !system_clock_out_q; // RULE15
    end
  end

  // ready hint for the user side
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      req_ready_q <= 1'h0;
    end else begin
      req_ready_q <= (st_q == ST_IDLE) && breq_s_q[1] && !float_all_q && ack_s_q[1] && !req_valid;
    end
  end

  // one-cycle pulse with each read word
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rdata_valid_q <= 1'h0;
    end else begin
      rdata_valid_q <= rd_done;
    end
  end

  // read word taken from the synchronised bus when the ack is seen
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rdata_q <= '0;
    end else if (rd_done) begin
      rdata_q <= ad_s1_q;
    end
  end
endmodule

// File: ctl_edge.sv
// registered control pins with float handling
`timescale 1ns/1ps
module ctl_edge (
  input  wire logic mclk,
  input  wire logic reset_n,
  ctl_if.dst        c,
  output logic      rd_n_q,
  output logic      wr_n_q,
  output logic      ale_q,
  output logic      read_data_enable_n_q,
  output logic      ctl_oe_n_q
);
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rd_n_q               <= 1'h1;
      wr_n_q               <= 1'h1;
      ale_q                <= 1'h0;
      read_data_enable_n_q <= 1'h1;
      ctl_oe_n_q           <= 1'h1;
    end else begin
      rd_n_q               <= c.rd_n;
      wr_n_q               <= c.wr_n;
      ale_q                <= c.ale;
      read_data_enable_n_q <= c.read_data_enable_n;
      ctl_oe_n_q           <= c.ctl_float;
    end
  end
endmodule

// File: ctl_if.sv
// control outputs carried from the sequencer to the edge driver
`timescale 1ns/1ps
interface ctl_if;
  logic       rd_n;
  logic       wr_n;
  logic       ale;
  logic       read_data_enable_n;
  logic       ad_drive;
  logic       ctl_float;
  modport src (output rd_n, output wr_n, output ale, output read_data_enable_n, output ad_drive, output ctl_float);
  modport dst (input rd_n, input wr_n, input ale, input read_data_enable_n, input ad_drive, input ctl_float);
endinterface

// File: mem_model.sv
// memory bank behind the transceivers
`timescale 1ns/1ps
module mem_model (
  input  wire logic        mclk,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic        ale,
  input  wire logic        de_n,
  input  wire logic [31:0] ad,
  input  wire logic [1:0]  lat,
  output logic             ack_n,
  output logic [31:0]      ad_in
);
  logic [31:0] mem [logic [27:0]];
  logic [27:0] a = 0;
  logic [3:0]  be_n = 0;
  logic [2:0]  cnt = 0;
  logic [1:0]  hold = 0;
  logic        rd_dir = 0;
  always @(posedge mclk) begin
    if (ale) begin
      a <= ad[31:4];
      be_n <= ad[3:0];
      cnt <= 0;
    end else if (!rd_n || !wr_n)
      cnt <= cnt + 3'h1;
    ack_n <= !((!rd_n || !wr_n) && !ale && cnt >= lat);
    if (!wr_n && !ack_n)
      for (int i = 0; i < 4; i++)
        if (!be_n[i]) mem[a][8*i+:8] <= ad[8*i+:8];
    hold <= !de_n ? 2'h3 : hold - (hold != 0);
    // direction follows the strobes only while the transceivers are shut
    if (de_n && hold == 0) rd_dir <= !rd_n;
    ad_in <= (rd_dir && (!de_n || hold != 0)) ? mem[a] : ~ad_in;
  end
endmodule

// File: tb.sv
// testbench: random word and byte traffic, grant and float-all
`timescale 1ns/1ps
module tb;
  import bus_pkg::*;
  logic mclk = 0, reset_n = 0, req_valid = 0, req_write = 0, bus_req_n = 1, second_interrupt_input = 0;
  logic [31:0] req_addr = 0, req_wdata = 0, ad_in, rdata_q, ad_out_q;
  logic [3:0] req_be_n = 0;
  logic [1:0] req_diag = 0, diag_q, lat = 0;
  logic ack_n, req_ready_q, rdata_valid_q, ad_oe_n_q, rd_n_q, wr_n_q, ale_q, read_data_enable_n_q;
  logic ctl_oe_n_q, bus_grant_out_q, bus_grant_oe_n_q, system_clock_out_q;
  logic [31:0] ref_m [8];
  logic [31:0] exp_q [$];
  int fail_count = 0, check_count = 0, n;
  bus_transceiver_control uut (
    .mclk                   (mclk),
    .reset_n                (reset_n),
    .req_valid              (req_valid),
    .req_write              (req_write),
    .req_addr               (req_addr),
    .req_be_n               (req_be_n),
    .req_diag               (req_diag),
    .req_wdata              (req_wdata),
    .req_ready_q            (req_ready_q),
    .rdata_q                (rdata_q),
    .rdata_valid_q          (rdata_valid_q),
    .ack_n                  (ack_n),
    .bus_req_n              (bus_req_n),
    .second_interrupt_input (second_interrupt_input),
    .ad_in                  (ad_in),
    .ad_out_q               (ad_out_q),
    .ad_oe_n_q              (ad_oe_n_q),
    .diag_q                 (diag_q),
    .rd_n_q                 (rd_n_q),
    .wr_n_q                 (wr_n_q),
    .ale_q                  (ale_q),
    .read_data_enable_n_q   (read_data_enable_n_q),
    .ctl_oe_n_q             (ctl_oe_n_q),
    .bus_grant_out_q        (bus_grant_out_q),
    .bus_grant_oe_n_q       (bus_grant_oe_n_q),
    .system_clock_out_q     (system_clock_out_q)
  );
  mem_model mem (.mclk(mclk), .rd_n(rd_n_q), .wr_n(wr_n_q), .ale(ale_q), .de_n(read_data_enable_n_q),
    .ad(ad_out_q), .lat(lat), .ack_n(ack_n), .ad_in(ad_in));
  always #2.5 mclk = ~mclk;
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task rst(input logic s);
    reset_n <= 0;
    second_interrupt_input <= s;
    repeat (3) @(posedge mclk);
    chk("reset", {29'h0, rd_n_q, wr_n_q, ad_oe_n_q}, 32'h7);
    reset_n <= 1;
    @(posedge mclk);
  endtask
  task op(input logic w, input logic [2:0] i, input logic [31:0] d, input logic [3:0] be);
    req_write <= w;
    req_addr <= {25'h0, i, 4'h0};
    req_wdata <= d;
    req_be_n <= be;
    req_diag <= d[1:0];
    lat <= 2'($urandom % 4);
    req_valid <= 1;
    n = 0;
    do @(posedge mclk); while (ale_q !== 1 && n++ < 50);
    chk("ale", {31'h0, ale_q}, 32'h1);
    req_valid <= 0;
    chk("diag", {30'h0, diag_q}, {30'h0, d[1:0]});
    if (w) for (int b = 0; b < 4; b++) begin
      if (!be[b]) ref_m[i][8*b+:8] = d[8*b+:8];
    end else exp_q.push_back(ref_m[i]);
    n = 0;
    do @(posedge mclk); while (req_ready_q !== 1 && n++ < 50);
    chk("ready", {31'h0, req_ready_q}, 32'h1);
  endtask
  always @(posedge mclk) if (rdata_valid_q === 1'b1) chk("rdata", rdata_q, exp_q.pop_front());
  initial begin
    void'($urandom(32'h8CEE));
    rst(0);
    for (int i = 0; i < 8; i++) op(1, 3'(i), $urandom, 4'h0);
    repeat (40) op(1'($urandom), 3'($urandom), $urandom, 4'($urandom));
    bus_req_n <= 0;
    n = 0;
    do @(posedge mclk); while (bus_grant_out_q !== 0 && n++ < 20);
    chk("grant_out", {31'h0, bus_grant_out_q}, 32'h0);
    @(posedge mclk);
    chk("grant", {30'h0, ctl_oe_n_q, ad_oe_n_q}, 32'h3);
    bus_req_n <= 1;
    repeat (5) @(posedge mclk);
    op(0, 3'h1, 32'h0, 4'h0);
    rst(1);
    @(posedge mclk);
    chk("float", {29'h0, bus_grant_oe_n_q, ctl_oe_n_q, ad_oe_n_q}, 32'h7);
    req_valid <= 1;
    repeat (4) @(posedge mclk);
    chk("refused", {30'h0, ale_q, rd_n_q}, 32'h1);
    req_valid <= 0;
    rst(0);
    op(0, 3'h2, 32'h0, 4'h0);
    repeat (10) @(posedge mclk);
    chk("pending", exp_q.size(), 32'h0);
    chk("grant_oe", {31'h0, bus_grant_oe_n_q}, 32'h0);
    conclude();
  end
  initial begin
    #20000;
    chk("timeout", 32'h0, 32'h1);
    conclude();
  end
endmodule
